// File: core/supply_supervisor_pkg.sv
// Shared constants and types for the supply supervisor and regulator control.
package supply_supervisor_pkg;

  // Supply thresholds in millivolts.
  localparam int unsigned POR_THRESHOLD_MV      = 1650;
  localparam int unsigned BOR_MIN_THRESHOLD_MV  = 1800;
  localparam int unsigned BOR_MAX_THRESHOLD_MV  = 3000;
  localparam int unsigned PVD_MIN_THRESHOLD_MV  = 1850;
  localparam int unsigned PVD_MAX_THRESHOLD_MV  = 3050;
  localparam int unsigned PVD_STEP_MV           = 200;

  // Level counts and field widths.
  localparam int unsigned BOR_LEVEL_COUNT = 5;
  localparam int unsigned PVD_LEVEL_COUNT = 7;
  localparam int unsigned LEVEL_W         = 3;
  localparam int unsigned OPT_W           = 4;

  // Option byte layout: bit 3 disables brownout, bits 2:0 pick the level.
  localparam int unsigned OPT_BOR_OFF_BIT = 3;
  localparam int unsigned OPT_LEVEL_LSB   = 0;

  // Reset values and highest valid levels.
  localparam logic [LEVEL_W-1:0] BOR_LEVEL_RESET = 3'h0;
  localparam logic [LEVEL_W-1:0] PVD_LEVEL_RESET = 3'h0;
  localparam logic [LEVEL_W-1:0] PVD_LEVEL_MAX   = 3'h6;
  localparam logic [LEVEL_W-1:0] BOR_LEVEL_MAX   = 3'h4;

  // Clock and start-up timing.
  localparam int unsigned CLK_HZ              = 20_000_000;
  localparam int unsigned STARTUP_BOR_US      = 3300;
  localparam int unsigned STARTUP_NOBOR_US    = 1000;
  localparam int unsigned STARTUP_BOR_CYCLES  =
    (STARTUP_BOR_US * (CLK_HZ / 1_000_000));
  localparam int unsigned STARTUP_NOBOR_CYCLES =
    (STARTUP_NOBOR_US * (CLK_HZ / 1_000_000));
  localparam int unsigned STARTUP_CNT_W       = 17;

  // Power modes requested by the core.
  typedef enum logic [2:0] {
    PM_RUN,
    PM_SLEEP,
    PM_LP_RUN,
    PM_LP_SLEEP,
    PM_STOP,
    PM_STANDBY
  } power_mode_e;

  // Regulator operating modes.
  typedef enum logic [1:0] {
    REG_MAIN,
    REG_LOW_POWER,
    REG_POWER_DOWN
  } regulator_mode_e;

  // Detector interrupt edge selection.
  typedef enum logic [1:0] {
    EDGE_NONE,
    EDGE_FALL,
    EDGE_RISE,
    EDGE_BOTH
  } edge_sel_e;

endpackage : supply_supervisor_pkg

// File: core/supply_level_detector.sv
// Software-enabled supply level detector with crossing events.
module supply_level_detector
  import supply_supervisor_pkg::*;
(
  input  wire logic                             ref_clk,
  input  wire logic                             nrst,
  input  wire logic                             detectEnable,
  input  wire supply_supervisor_pkg::edge_sel_e edgeSel,
  input  wire logic                             belowSync,
  output logic                                  levelBelow,
  output logic                                  crossEvent
);

  logic enaReg;
  logic enaNext;
  logic belowReg;
  logic belowNext;
  logic eventReg;
  logic eventNext;

  // A freshly enabled detector takes its first sample silently, so the
  // enable itself never looks like a crossing.
  always_comb
  begin
    enaNext   = detectEnable;
    belowNext = detectEnable ? belowSync : 1'b0; // RQ7
    eventNext = 1'b0;
    if (detectEnable && enaReg && (belowSync != belowReg))
    begin
      case (edgeSel)
        EDGE_FALL: eventNext = belowSync;  // RQ6
        EDGE_RISE: eventNext = !belowSync; // RQ6
        EDGE_BOTH: eventNext = 1'b1;       // RQ6
        default:   eventNext = 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      enaReg   <= 1'b0;
      belowReg <= 1'b0;
      eventReg <= 1'b0;
    end
    else
    begin
      enaReg   <= enaNext;
      belowReg <= belowNext;
      eventReg <= eventNext;
    end
  end

  assign levelBelow = belowReg; // RQ13
  assign crossEvent = eventReg;

  property p_disabled_quiet;
    @(posedge ref_clk) disable iff (!nrst)
    !detectEnable |=> !crossEvent && !levelBelow;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) // RQ7
    else $error("Detector active while disabled.");

  property p_fall_event;
    @(posedge ref_clk) disable iff (!nrst)
    (detectEnable && enaReg && edgeSel == EDGE_FALL && belowSync
     && !belowReg) |=> crossEvent;
  endproperty
  a_fall_event: assert property (p_fall_event) // RQ6
    else $error("Falling crossing did not raise an event.");

endmodule : supply_level_detector

// File: core/supply_supervisor_regulator_ctrl.sv
// Reset hold, option load, detector and regulator mode control.
//
// Function
// RQ1 - Internal reset held while supply is below power-on or brownout level (brownoutBelowVec has 3 bits: levels 3 and 4 never hold it).
// RQ2 - Option bytes load once the supply threshold is reached.
// RQ3 - Options keep or change brownout level, or disable brownout for good.
// RQ4 - Optional automatic switch-off of internal reference during Stop.
// RQ5 - Detector compares supply against one of seven software levels.
// RQ6 - Detector event on falling, rising or both crossings as configured.
// RQ7 - Software enables detector; disabled detector gives no result or event.
// RQ8 - Run mode uses the main regulator mode.
// RQ9 - Low-power run, low-power sleep and Stop use low-power regulator.
// RQ10 - Standby powers the regulator down with the kernel unpowered.
// RQ11 - Standby loses kernel state except the standby domain.
// RQ12 - Start-up lasts 3.3 ms with brownout active, 1 ms without.
// RQ13 - Status bit shows supply above or below detector threshold.
module supply_supervisor_regulator_ctrl
  import supply_supervisor_pkg::*;
(
  input  wire logic                                   ref_clk,
  input  wire logic                                   nrst,
  input  wire logic                                   supplyAbovePor,
  input  wire logic [LEVEL_W-1:0]                     brownoutBelowVec,
  input  wire logic [PVD_LEVEL_COUNT-1:0]             detBelowVec,
  input  wire logic [OPT_W-1:0]                       optionByte,
  input  wire logic                                   optionValid,
  input  wire logic                                   brownoutAtPowerUp,
  input  wire logic                                   detectEnable,
  input  wire logic [LEVEL_W-1:0]                     detectLevel,
  input  wire supply_supervisor_pkg::edge_sel_e       detectEdge,
  input  wire logic                                   vrefOffInStop,
  input  wire supply_supervisor_pkg::power_mode_e     powerMode,
  output logic                                        sysRst_n,
  output logic                                        optionLoadReq,
  output logic                                        brownoutEnabled,
  output logic [LEVEL_W-1:0]                          brownoutLevel,
  output logic [LEVEL_W-1:0]                          supplyDetectThreshold,
  output logic                                        detectBelow,
  output logic                                        detectIrq,
  output supply_supervisor_pkg::regulator_mode_e      regulatorMode,
  output logic                                        vrefEnable,
  output logic                                        kernelPowered,
  output logic                                        kernelStateClear_n
);

  typedef enum {
    ST_HOLD,
    ST_OPTLOAD,
    ST_STARTUP,
    ST_RUN
  } seq_e;

  // Each vector bit is one comparator output; the level picks which one.
  function automatic logic belowLevel(input logic [LEVEL_W-1:0] lvl,
                                      input logic [7:0]         vec);
    belowLevel = vec[lvl];
  endfunction : belowLevel

  // Two-flop synchronisers for the analog comparator outputs.
  logic       porMeta;
  logic       porSync;
  logic [7:0] borMeta;
  logic [7:0] borSync;
  logic [7:0] detMeta;
  logic [7:0] detSync;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      porMeta <= 1'b0;
      porSync <= 1'b0;
      borMeta <= 8'h00;
      borSync <= 8'h00;
      detMeta <= 8'h00;
      detSync <= 8'h00;
    end
    else
    begin
      porMeta <= supplyAbovePor;
      porSync <= porMeta;
      borMeta <= {5'h00, brownoutBelowVec};
      borSync <= borMeta;
      detMeta <= {1'b0, detBelowVec};
      detSync <= detMeta;
    end
  end

  seq_e                     stateReg;
  seq_e                     stateNext;
  logic [STARTUP_CNT_W-1:0] cntReg;
  logic [STARTUP_CNT_W-1:0] cntNext;
  logic                     borEnReg;
  logic                     borEnNext;
  logic [LEVEL_W-1:0]       borLvlReg;
  logic [LEVEL_W-1:0]       borLvlNext;
  logic                     borUpReg;
  logic                     borUpNext;
  logic                     reqReg;
  logic                     reqNext;
  logic                     supplyLow;

  // Below threshold means the power-on comparator is low, or brownout is
  // live, the chosen brownout level is 0 to 2, and the supply sits under it.
  assign supplyLow = !porSync ||
                     (borEnReg && belowLevel(borLvlReg, borSync)); // RQ1

  always_comb
  begin
    stateNext  = stateReg;
    cntNext    = cntReg;
    borEnNext  = borEnReg;
    borLvlNext = borLvlReg;
    borUpNext  = borUpReg;
    reqNext    = 1'b0;
    if (supplyLow)
    begin
      stateNext = ST_HOLD; // RQ1
      cntNext   = '0;
    end
    else
    begin
      case (stateReg)
        ST_HOLD:
        begin
          stateNext = ST_OPTLOAD; // RQ2
          borUpNext = borEnReg;
          reqNext   = 1'b1;
        end
        ST_OPTLOAD:
        begin
          reqNext = !optionValid;
          if (optionValid)
          begin
            // Disabling is sticky until the next power-on reset.
            if (optionByte[OPT_BOR_OFF_BIT])
              borEnNext = 1'b0; // RQ3
            else if (optionByte[OPT_LEVEL_LSB +: LEVEL_W] <= BOR_LEVEL_MAX)
              borLvlNext = optionByte[OPT_LEVEL_LSB +: LEVEL_W]; // RQ3
            stateNext = ST_STARTUP;
          end
        end
        ST_STARTUP:
        begin
          cntNext = cntReg + 1'b1;
          if (cntReg == (borUpReg ?
                STARTUP_CNT_W'(STARTUP_BOR_CYCLES - 1) :
                STARTUP_CNT_W'(STARTUP_NOBOR_CYCLES - 1))) // RQ12
          begin
            stateNext = ST_RUN;
            cntNext   = '0;
          end
        end
        ST_RUN:    stateNext = ST_RUN;
        default:   stateNext = ST_HOLD;
      endcase
    end
  end

  // The power-up brownout strap is caught after reset release, while the
  // sequencer still holds, never through the asynchronous reset path.
  logic strapTaken;
  logic strapNext;

  always_comb
  begin
    strapNext = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stateReg   <= ST_HOLD;
      cntReg     <= '0;
      borEnReg   <= 1'b0;
      borLvlReg  <= BOR_LEVEL_RESET;
      borUpReg   <= 1'b0;
      reqReg     <= 1'b0;
      strapTaken <= 1'b0;
    end
    else
    begin
      stateReg   <= stateNext;
      cntReg     <= cntNext;
      borEnReg   <= strapTaken ? borEnNext : brownoutAtPowerUp;
      borLvlReg  <= borLvlNext;
      borUpReg   <= borUpNext;
      reqReg     <= reqNext;
      strapTaken <= strapNext;
    end
  end

  // Detector: software level, clamped to the seven valid levels.
  logic [LEVEL_W-1:0] detLvl;
  logic               detBelowRaw;
  logic               detBelowOut;
  logic               detEvent;

  assign detLvl      = (detectLevel > PVD_LEVEL_MAX) ? PVD_LEVEL_MAX
                                                     : detectLevel; // RQ5
  assign detBelowRaw = belowLevel(detLvl, detSync); // RQ5

  supply_level_detector i_supply_level_detector (
    .ref_clk      (ref_clk),
    .nrst         (nrst),
    .detectEnable (detectEnable),
    .edgeSel      (detectEdge),
    .belowSync    (detBelowRaw),
    .levelBelow   (detBelowOut),
    .crossEvent   (detEvent)
  );

  // Regulator and reference control.
  regulator_mode_e regModeReg;
  regulator_mode_e regModeNext;
  logic            vrefReg;
  logic            vrefNext;
  logic            kernReg;
  logic            kernNext;

  always_comb
  begin
    case (powerMode)
      PM_RUN, PM_SLEEP: regModeNext = REG_MAIN; // RQ8
      PM_LP_RUN, PM_LP_SLEEP, PM_STOP:
        regModeNext = REG_LOW_POWER; // RQ9
      PM_STANDBY: regModeNext = REG_POWER_DOWN; // RQ10
      default:    regModeNext = REG_MAIN;
    endcase
    vrefNext = !((powerMode == PM_STOP) && vrefOffInStop) &&
               (powerMode != PM_STANDBY); // RQ4
    kernNext = (powerMode != PM_STANDBY); // RQ11
  end

  logic               rstReg;
  logic [LEVEL_W-1:0] thrReg;
  logic               belowReg;
  logic               irqReg;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      regModeReg <= REG_MAIN;
      vrefReg    <= 1'b1;
      kernReg    <= 1'b1;
      rstReg     <= 1'b0;
      thrReg     <= PVD_LEVEL_RESET;
      belowReg   <= 1'b0;
      irqReg     <= 1'b0;
    end
    else
    begin
      regModeReg <= regModeNext;
      vrefReg    <= vrefNext;
      kernReg    <= kernNext;
      rstReg     <= (stateNext == ST_RUN); // RQ1
      thrReg     <= detLvl;
      belowReg   <= detBelowOut; // RQ13
      irqReg     <= detEvent;    // RQ6
    end
  end

  assign sysRst_n              = rstReg;
  assign optionLoadReq         = reqReg;
  assign brownoutEnabled       = borEnReg;
  assign brownoutLevel         = borLvlReg;
  assign supplyDetectThreshold = thrReg;
  assign detectBelow           = belowReg;
  assign detectIrq             = irqReg;
  assign regulatorMode         = regModeReg;
  assign vrefEnable            = vrefReg;
  assign kernelPowered         = kernReg;
  // Standby domain logic is outside this block and ignores this clear.
  assign kernelStateClear_n    = kernReg; // RQ11

  property p_low_holds_reset;
    @(posedge ref_clk) disable iff (!nrst)
    supplyLow |=> !sysRst_n;
  endproperty
  a_low_holds_reset: assert property (p_low_holds_reset) // RQ1
    else $error("Reset released while supply low.");

  property p_load_after_hold;
    @(posedge ref_clk) disable iff (!nrst)
    (stateReg == ST_HOLD && !supplyLow) |=> optionLoadReq;
  endproperty
  a_load_after_hold: assert property (p_load_after_hold) // RQ2
    else $error("Option load not requested after supply good.");

  property p_bor_disable;
    @(posedge ref_clk) disable iff (!nrst)
    (stateReg == ST_OPTLOAD && optionValid && !supplyLow &&
     optionByte[OPT_BOR_OFF_BIT]) |=> !brownoutEnabled;
  endproperty
  a_bor_disable: assert property (p_bor_disable) // RQ3
    else $error("Brownout not disabled by option.");

  property p_vref_stop;
    @(posedge ref_clk) disable iff (!nrst)
    (powerMode == PM_STOP && vrefOffInStop) |=> !vrefEnable;
  endproperty
  a_vref_stop: assert property (p_vref_stop) // RQ4
    else $error("Reference still on in Stop.");

  property p_run_main;
    @(posedge ref_clk) disable iff (!nrst)
    powerMode == PM_RUN |=> regulatorMode == REG_MAIN;
  endproperty
  a_run_main: assert property (p_run_main) // RQ8
    else $error("Run mode without main regulator.");

  property p_lp_modes;
    @(posedge ref_clk) disable iff (!nrst)
    (powerMode inside {PM_LP_RUN, PM_LP_SLEEP, PM_STOP})
      |=> regulatorMode == REG_LOW_POWER;
  endproperty
  a_lp_modes: assert property (p_lp_modes) // RQ9
    else $error("Low-power mode without low-power regulator.");

  property p_standby;
    @(posedge ref_clk) disable iff (!nrst)
    powerMode == PM_STANDBY
      |=> regulatorMode == REG_POWER_DOWN && !kernelPowered;
  endproperty
  a_standby: assert property (p_standby) // RQ10
    else $error("Standby without regulator power-down.");

  property p_startup_len;
    @(posedge ref_clk) disable iff (!nrst)
    (stateReg == ST_STARTUP && !supplyLow &&
     cntReg < STARTUP_CNT_W'(STARTUP_NOBOR_CYCLES - 1))
      |=> !sysRst_n;
  endproperty
  a_startup_len: assert property (p_startup_len) // RQ12
    else $error("Reset released before the start-up wait ended.");

endmodule : supply_supervisor_regulator_ctrl

// File: tb/supply_supervisor_regulator_ctrl_tb.sv
// Self-checking bench for the supply supervisor and regulator control.
module supply_supervisor_regulator_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import supply_supervisor_pkg::*;

  typedef struct packed {
    logic             en;
    logic [2:0]       lvl;
    edge_sel_e        sel;
    logic [6:0]       pre;
    logic [6:0]       post;
    logic [7:0]       nIrq;
    logic             below;
    logic [2:0]       thr;
  } det_row_s;

  typedef struct packed {
    power_mode_e      mode;
    logic             vrefOff;
    regulator_mode_e  regMode;
    logic             vref;
    logic             kern;
  } mode_row_s;

  logic                                ref_clk;
  logic                                nrst;
  logic                                supplyAbovePor;
  logic [LEVEL_W-1:0]                  brownoutBelowVec;
  logic [PVD_LEVEL_COUNT-1:0]          detBelowVec;
  logic [OPT_W-1:0]                    optionByte;
  logic                                optionValid;
  logic                                brownoutAtPowerUp;
  logic                                detectEnable;
  logic [LEVEL_W-1:0]                  detectLevel;
  edge_sel_e                           detectEdge;
  logic                                vrefOffInStop;
  power_mode_e                         powerMode;
  logic                                sysRst_n;
  logic                                optionLoadReq;
  logic                                brownoutEnabled;
  logic [LEVEL_W-1:0]                  brownoutLevel;
  logic [LEVEL_W-1:0]                  supplyDetectThreshold;
  logic                                detectBelow;
  logic                                detectIrq;
  regulator_mode_e                     regulatorMode;
  logic                                vrefEnable;
  logic                                kernelPowered;
  logic                                kernelStateClear_n;
  int                                  mismatches;
  int                                  nChecks;
  int                                  cycleCount;

  // Each row settles on its first pattern, then counts events after the
  // second one, so only the crossing under test is counted.
  det_row_s detRows [8] = '{
    '{1'b1, 3'h0, EDGE_FALL, 7'h00, 7'h7f, 8'h01, 1'b1, 3'h0},
    '{1'b1, 3'h3, EDGE_FALL, 7'h7f, 7'h00, 8'h00, 1'b0, 3'h3},
    '{1'b1, 3'h3, EDGE_RISE, 7'h7f, 7'h00, 8'h01, 1'b0, 3'h3},
    '{1'b1, 3'h6, EDGE_RISE, 7'h00, 7'h40, 8'h00, 1'b1, 3'h6},
    '{1'b1, 3'h7, EDGE_BOTH, 7'h00, 7'h40, 8'h01, 1'b1, 3'h6},
    '{1'b1, 3'h5, EDGE_BOTH, 7'h7f, 7'h1f, 8'h01, 1'b0, 3'h5},
    '{1'b1, 3'h2, EDGE_NONE, 7'h00, 7'h7f, 8'h00, 1'b1, 3'h2},
    '{1'b0, 3'h1, EDGE_BOTH, 7'h00, 7'h7f, 8'h00, 1'b0, 3'h1}
  };

  mode_row_s modeRows [9] = '{
    '{PM_RUN,      1'b0, REG_MAIN,       1'b1, 1'b1},
    '{PM_LP_RUN,   1'b0, REG_LOW_POWER,  1'b1, 1'b1},
    '{PM_LP_SLEEP, 1'b0, REG_LOW_POWER,  1'b1, 1'b1},
    '{PM_STOP,     1'b0, REG_LOW_POWER,  1'b1, 1'b1},
    '{PM_STOP,     1'b1, REG_LOW_POWER,  1'b0, 1'b1},
    '{PM_RUN,      1'b1, REG_MAIN,       1'b1, 1'b1},
    '{PM_STANDBY,  1'b0, REG_POWER_DOWN, 1'b0, 1'b0},
    '{PM_SLEEP,    1'b1, REG_MAIN,       1'b1, 1'b1},
    '{PM_RUN,      1'b0, REG_MAIN,       1'b1, 1'b1}
  };

  supply_supervisor_regulator_ctrl i_supply_supervisor_regulator_ctrl (
    .ref_clk               (ref_clk),
    .nrst                  (nrst),
    .supplyAbovePor        (supplyAbovePor),
    .brownoutBelowVec      (brownoutBelowVec),
    .detBelowVec           (detBelowVec),
    .optionByte            (optionByte),
    .optionValid           (optionValid),
    .brownoutAtPowerUp     (brownoutAtPowerUp),
    .detectEnable          (detectEnable),
    .detectLevel           (detectLevel),
    .detectEdge            (detectEdge),
    .vrefOffInStop         (vrefOffInStop),
    .powerMode             (powerMode),
    .sysRst_n              (sysRst_n),
    .optionLoadReq         (optionLoadReq),
    .brownoutEnabled       (brownoutEnabled),
    .brownoutLevel         (brownoutLevel),
    .supplyDetectThreshold (supplyDetectThreshold),
    .detectBelow           (detectBelow),
    .detectIrq             (detectIrq),
    .regulatorMode         (regulatorMode),
    .vrefEnable            (vrefEnable),
    .kernelPowered         (kernelPowered),
    .kernelStateClear_n    (kernelStateClear_n)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic conclude;
    $display("Checks %0d, mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  task automatic check(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
    nChecks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  // Full power-on: reset, low supply, supply good, option load, start-up.
  task automatic powerUp(input logic strap, input logic [3:0] opt,
                         input int n);
    int k;
    nrst = 1'b0;
    supplyAbovePor = 1'b0;
    brownoutBelowVec = 3'h0;
    brownoutAtPowerUp = strap;
    optionValid = 1'b0;
    optionByte = opt;
    cyc(8);
    check("sysRst_n", 8'h00, sysRst_n);
    check("regulatorMode", REG_MAIN, regulatorMode);
    nrst = 1'b1;
    cyc(20);
    check("sysRst_n", 8'h00, sysRst_n);
    check("optionLoadReq", 8'h00, optionLoadReq);
    supplyAbovePor = 1'b1;
    k = 0;
    while (optionLoadReq !== 1'b1 && k < 10)
    begin
      cyc(1);
      k++;
    end
    check("optionLoadReq", 8'h01, optionLoadReq);
    check("sysRst_n", 8'h00, sysRst_n);
    optionValid = 1'b1;
    k = 0;
    while (sysRst_n !== 1'b1 && k < n + 100)
    begin
      cyc(1);
      k++;
      if (optionLoadReq === 1'b0)
        optionValid = 1'b0;
    end
    check("startupLength", 8'h01, {7'h0, k >= n && k <= n + 4});
  endtask : powerUp

  always @(posedge ref_clk)
  begin
    cycleCount++;
    // Two start-ups of 66000 and 20000 cycles dominate the run.
    if (cycleCount == 95000)
    begin
      mismatches++;
      conclude();
    end
  end

  initial
  begin
    logic [7:0] n;
    mismatches = 0;
    nChecks = 0;
    cycleCount = 0;
    detBelowVec = 7'h00;
    detectEnable = 1'b0;
    detectLevel = 3'h0;
    detectEdge = EDGE_NONE;
    vrefOffInStop = 1'b0;
    powerMode = PM_RUN;
    powerUp(1'b1, 4'h2, STARTUP_BOR_CYCLES);
    check("brownoutEnabled", 8'h01, brownoutEnabled);
    check("brownoutLevel", 8'h02, brownoutLevel);
    foreach (detRows[i])
    begin
      detectEnable = detRows[i].en;
      detectLevel = detRows[i].lvl;
      detectEdge = detRows[i].sel;
      detBelowVec = detRows[i].pre;
      cyc(8);
      detBelowVec = detRows[i].post;
      n = 8'h00;
      repeat (8)
      begin
        cyc(1);
        if (detectIrq === 1'b1)
          n++;
      end
      check("detectIrq", detRows[i].nIrq, n);
      check("detectBelow", detRows[i].below, detectBelow);
      if (detRows[i].en)
        check("threshold", detRows[i].thr, supplyDetectThreshold);
    end
    // Enabling while the supply already sits below must not look like
    // a crossing; the first enabled sample is taken silently.
    detectEnable = 1'b1;
    n = 8'h00;
    repeat (8)
    begin
      cyc(1);
      if (detectIrq === 1'b1)
        n++;
    end
    check("enableIrq", 8'h00, n);
    check("enableBelow", 8'h01, detectBelow);
    foreach (modeRows[i])
    begin
      powerMode = modeRows[i].mode;
      vrefOffInStop = modeRows[i].vrefOff;
      cyc(3);
      check("regulatorMode", modeRows[i].regMode, regulatorMode);
      check("vrefEnable", modeRows[i].vref, vrefEnable);
      check("kernelPowered", modeRows[i].kern, kernelPowered);
      check("stateClear", modeRows[i].kern, kernelStateClear_n);
    end
    brownoutBelowVec = 3'h4;
    cyc(6);
    check("sysRst_n", 8'h00, sysRst_n);
    powerUp(1'b0, 4'h8, STARTUP_NOBOR_CYCLES);
    check("brownoutEnabled", 8'h00, brownoutEnabled);
    brownoutBelowVec = 3'h7;
    cyc(10);
    check("sysRst_n", 8'h01, sysRst_n);
    supplyAbovePor = 1'b0;
    cyc(6);
    check("sysRst_n", 8'h00, sysRst_n);
    conclude();
  end

endmodule : supply_supervisor_regulator_ctrl_tb
